// [logic/awc_pkg.sv]
`default_nettype none
package awc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int RES_W  = 12;
  localparam int PAD_W  = WORD_W - RES_W;
  localparam int IRQ_N  = 2;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_TRACK    = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_UPPER_HI = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_UPPER_LO = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_LOWER_HI = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_LOWER_LO = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_CONV_HI  = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_CONV_LO  = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h24;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTL_EN    = 7;
  localparam int CTL_BURST = 6;
  localparam int CTL_DONE  = 5;
  localparam int CTL_BUSY  = 4;
  localparam int CTL_WIN   = 3;
  localparam int CTL_LJST  = 2;
  localparam int CTL_MODE  = 0;
  localparam int MODE_W    = 2;

  // flag vector / interrupt status bit positions
  localparam int IRQ_WIN  = 0;
  localparam int IRQ_DONE = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CTRL_RST  = 8'h00;
  localparam logic [DATA_W-1:0] TRACK_RST = 8'hFF;
  localparam logic [DATA_W-1:0] MASK_RST  = 8'h00;
  localparam logic [WORD_W-1:0] UPPER_RST = 16'hFFFF;
  localparam logic [WORD_W-1:0] LOWER_RST = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } awc_bus_req_t;

  typedef struct packed {
    logic [WORD_W-1:0] upper;
    logic [WORD_W-1:0] lower;
  } awc_limits_t;

  typedef struct packed {
    logic             valid;
    logic [RES_W-1:0] result;
  } awc_conv_t;

  // place a raw result in the 16-bit word, right or left justified
  function automatic logic [WORD_W-1:0] awc_justify(input logic [RES_W-1:0] res, input logic left);
    awc_justify = left ? {res, {PAD_W{1'b0}}} : {{PAD_W{1'b0}}, res};
  endfunction

endpackage
`default_nettype wire

// [logic/awc_window_cmp.sv]
`default_nettype none
module awc_window_cmp
  import awc_pkg::*;
(
  input  wire logic [awc_pkg::WORD_W-1:0] word_i,
  input  wire awc_pkg::awc_limits_t       limits_i,
  output logic                            inside_mode_o,
  output logic                            hit_o
);

  always_comb begin
    // mode comes only from the ordering of the two limits
    inside_mode_o = limits_i.upper < limits_i.lower;
    if (inside_mode_o) begin
      hit_o = (word_i > limits_i.upper) && (word_i < limits_i.lower);
    end else begin
      hit_o = (word_i < limits_i.lower) || (word_i > limits_i.upper);
    end
  end

endmodule
`default_nettype wire

// [logic/awc_sticky.sv]
`default_nettype none
module awc_sticky #(
  parameter int W = 2
) (
  input  wire logic         clock_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] next_q;

  // set wins over a clear in the same cycle
  always_comb begin
    next_q = (q_o & ~clr_i) | set_i;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      q_o <= '0;
    end else begin
      q_o <= next_q;
    end
  end

endmodule
`default_nettype wire

// [logic/awc_top.sv]
// Functional notes
// - every new conversion word is checked against both limits in hardware
// - window flag is readable in the control register for polling or interrupt
// - two 16-bit limits, each written as a high and a low byte register
// - upper limit below lower limit: flag when strictly between them
// - otherwise: flag when strictly below lower or strictly above upper
// - inside or outside mode follows only from the limit ordering
// - result is 12-bit unsigned, compared with no sign extension
// - limits compare against the word in its selected justification
//
// Strobed register access and the placing of the registers are this design's own decisions.
`default_nettype none
module awc_top
  import awc_pkg::*;
(
  input  wire logic                       clock_i,
  input  wire logic                       srst_i,
  input  wire awc_pkg::awc_bus_req_t      bus_i,
  output logic [awc_pkg::DATA_W-1:0]      rd_data_o,
  input  wire awc_pkg::awc_conv_t         conv_i,
  input  wire logic                       conv_busy_i,
  output logic                            conv_start_o,
  output logic                            converter_enable_o,
  output logic                            burst_mode_enable_o,
  output logic [awc_pkg::MODE_W-1:0]      start_mode_o,
  output logic [awc_pkg::DATA_W-1:0]      tracking_ctrl_o,
  output logic                            window_compare_flag_o,
  output logic                            irq_o
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic wr_hit(input awc_bus_req_t b, input logic [ADDR_W-1:0] a);
    wr_hit = b.wr && (b.addr == a);
  endfunction

  function automatic logic rd_hit(input awc_bus_req_t b, input logic [ADDR_W-1:0] a);
    rd_hit = b.rd && (b.addr == a);
  endfunction

  // ----------------------------------------------------------------
  // configuration state
  // ----------------------------------------------------------------
  logic                converter_enable;
  logic                burst_mode_enable;
  logic                left_justify;
  logic [MODE_W-1:0]   start_mode;
  logic [DATA_W-1:0]   tracking_ctrl;
  logic [DATA_W-1:0]   irq_mask;
  awc_limits_t         limits;

  logic                next_converter_enable;
  logic                next_burst_mode_enable;
  logic                next_left_justify;
  logic [MODE_W-1:0]   next_start_mode;
  logic [DATA_W-1:0]   next_tracking_ctrl;
  logic [DATA_W-1:0]   next_irq_mask;
  awc_limits_t         next_limits;

  always_comb begin
    next_converter_enable  = converter_enable;
    next_burst_mode_enable = burst_mode_enable;
    next_left_justify      = left_justify;
    next_start_mode        = start_mode;
    next_tracking_ctrl     = tracking_ctrl;
    next_irq_mask          = irq_mask;
    next_limits            = limits;
    if (wr_hit(bus_i, ADDR_CTRL)) begin
      next_converter_enable  = bus_i.wdata[CTL_EN];
      next_burst_mode_enable = bus_i.wdata[CTL_BURST];
      next_left_justify      = bus_i.wdata[CTL_LJST];
      next_start_mode        = bus_i.wdata[CTL_MODE +: MODE_W];
    end
    if (wr_hit(bus_i, ADDR_TRACK)) begin
      next_tracking_ctrl = bus_i.wdata;
    end
    if (wr_hit(bus_i, ADDR_IRQ_MASK)) begin
      next_irq_mask = bus_i.wdata;
    end
    // each 16-bit limit is loaded one byte at a time
    if (wr_hit(bus_i, ADDR_UPPER_HI)) begin
      next_limits.upper[WORD_W-1:DATA_W] = bus_i.wdata;
    end
    if (wr_hit(bus_i, ADDR_UPPER_LO)) begin
      next_limits.upper[DATA_W-1:0] = bus_i.wdata;
    end
    if (wr_hit(bus_i, ADDR_LOWER_HI)) begin
      next_limits.lower[WORD_W-1:DATA_W] = bus_i.wdata;
    end
    if (wr_hit(bus_i, ADDR_LOWER_LO)) begin
      next_limits.lower[DATA_W-1:0] = bus_i.wdata;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      converter_enable  <= CTRL_RST[CTL_EN];
      burst_mode_enable <= CTRL_RST[CTL_BURST];
      left_justify      <= CTRL_RST[CTL_LJST];
      start_mode        <= CTRL_RST[CTL_MODE +: MODE_W];
      tracking_ctrl     <= TRACK_RST;
      irq_mask          <= MASK_RST;
      limits.upper      <= UPPER_RST;
      limits.lower      <= LOWER_RST;
    end else begin
      converter_enable  <= next_converter_enable;
      burst_mode_enable <= next_burst_mode_enable;
      left_justify      <= next_left_justify;
      start_mode        <= next_start_mode;
      tracking_ctrl     <= next_tracking_ctrl;
      irq_mask          <= next_irq_mask;
      limits            <= next_limits;
    end
  end

  // ----------------------------------------------------------------
  // conversion capture and window compare
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] new_word;
  logic [WORD_W-1:0] conv_word;
  logic [WORD_W-1:0] next_conv_word;
  logic              new_conv;
  logic              win_hit;

  always_comb begin
    // unsigned 12-bit result placed per the justification bit
    new_word       = awc_justify(conv_i.result, left_justify);
    new_conv       = conv_i.valid && converter_enable;
    next_conv_word = new_conv ? new_word : conv_word;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      conv_word <= WORD_RST;
    end else begin
      conv_word <= next_conv_word;
    end
  end

  // compare the word as it enters the output register pair
  awc_window_cmp u_cmp (
    .word_i        (new_word),
    .limits_i      (limits),
    .inside_mode_o (),
    .hit_o         (win_hit)
  );

  // ----------------------------------------------------------------
  // event flags and interrupt status
  // ----------------------------------------------------------------
  logic [IRQ_N-1:0] events;
  logic [IRQ_N-1:0] ctl_flags;
  logic [IRQ_N-1:0] ctl_clr;
  logic [IRQ_N-1:0] irq_stat;
  logic [IRQ_N-1:0] stat_clr;

  always_comb begin
    events           = '0;
    events[IRQ_WIN]  = new_conv && win_hit;
    events[IRQ_DONE] = new_conv;
    ctl_clr          = '0;
    // writing zero clears a flag, writing one leaves it alone
    if (wr_hit(bus_i, ADDR_CTRL)) begin
      ctl_clr[IRQ_WIN]  = ~bus_i.wdata[CTL_WIN];
      ctl_clr[IRQ_DONE] = ~bus_i.wdata[CTL_DONE];
    end
    stat_clr = rd_hit(bus_i, ADDR_IRQ_STAT) ? {IRQ_N{1'b1}} : {IRQ_N{1'b0}};
  end

  awc_sticky #(.W(IRQ_N)) u_ctl_flags (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .set_i   (events),
    .clr_i   (ctl_clr),
    .q_o     (ctl_flags)
  );

  awc_sticky #(.W(IRQ_N)) u_irq_stat (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .set_i   (events),
    .clr_i   (stat_clr),
    .q_o     (irq_stat)
  );

  // ----------------------------------------------------------------
  // read data and registered outputs
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_view;
  logic [DATA_W-1:0] next_rd_data;
  logic              next_conv_start;
  logic              next_irq;
  logic [IRQ_N-1:0]  next_stat;

  always_comb begin
    ctrl_view                        = '0;
    ctrl_view[CTL_EN]                = converter_enable;
    ctrl_view[CTL_BURST]             = burst_mode_enable;
    ctrl_view[CTL_DONE]              = ctl_flags[IRQ_DONE];
    ctrl_view[CTL_BUSY]              = conv_busy_i;
    ctrl_view[CTL_WIN]               = ctl_flags[IRQ_WIN];
    ctrl_view[CTL_LJST]              = left_justify;
    ctrl_view[CTL_MODE +: MODE_W]    = start_mode;
    next_rd_data = '0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        ADDR_CTRL:     next_rd_data = ctrl_view;
        ADDR_TRACK:    next_rd_data = tracking_ctrl;
        ADDR_UPPER_HI: next_rd_data = limits.upper[WORD_W-1:DATA_W];
        ADDR_UPPER_LO: next_rd_data = limits.upper[DATA_W-1:0];
        ADDR_LOWER_HI: next_rd_data = limits.lower[WORD_W-1:DATA_W];
        ADDR_LOWER_LO: next_rd_data = limits.lower[DATA_W-1:0];
        ADDR_CONV_HI:  next_rd_data = conv_word[WORD_W-1:DATA_W];
        ADDR_CONV_LO:  next_rd_data = conv_word[DATA_W-1:0];
        ADDR_IRQ_STAT: next_rd_data = {{(DATA_W-IRQ_N){1'b0}}, irq_stat};
        ADDR_IRQ_MASK: next_rd_data = irq_mask;
        default:       next_rd_data = '0;
      endcase
    end
    // a one written to the busy bit starts a conversion when the same write also sets the enable bit
    next_conv_start = wr_hit(bus_i, ADDR_CTRL) && bus_i.wdata[CTL_BUSY] && bus_i.wdata[CTL_EN];
    // irq follows the status value being registered this edge
    next_stat = (irq_stat & ~stat_clr) | events;
    next_irq  = |(next_stat & next_irq_mask[IRQ_N-1:0]);
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rd_data_o    <= '0;
      conv_start_o <= 1'b0;
      irq_o        <= 1'b0;
    end else begin
      rd_data_o    <= next_rd_data;
      conv_start_o <= next_conv_start;
      irq_o        <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // mirrored configuration outputs
  // ----------------------------------------------------------------
  always_comb begin
    converter_enable_o    = converter_enable;
    burst_mode_enable_o   = burst_mode_enable;
    start_mode_o          = start_mode;
    tracking_ctrl_o       = tracking_ctrl;
    window_compare_flag_o = ctl_flags[IRQ_WIN];
  end

endmodule
`default_nettype wire

// [verification/awc_conv_model.sv]
`default_nettype none
module awc_conv_model
  import awc_pkg::*;
(
  input  wire logic                      clock_i,
  input  wire logic                      srst_i,
  input  wire logic                      start_i,
  input  wire logic [awc_pkg::RES_W-1:0] result_i,
  input  wire logic [3:0]                dly_i,
  output var  awc_pkg::awc_conv_t        conv_o,
  output logic                           busy_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0]       cnt;
  logic [RES_W-1:0] last;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      busy_o <= 1'b0;
      cnt    <= 4'h0;
      last   <= '0;
      conv_o <= '0;
    end else begin
      // result lines released between results: show the inverted stale value
      conv_o <= '{valid: 1'b0, result: ~last};
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        cnt    <= dly_i;
      end else if (busy_o && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy_o) begin
        busy_o <= 1'b0;
        conv_o <= '{valid: 1'b1, result: result_i};
        last   <= result_i;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/awc_properties.sv]
`default_nettype none
module awc_checker
  import awc_pkg::*;
(
  input  wire logic                       clock_i,
  input  wire logic                       srst_i,
  input  wire awc_pkg::awc_bus_req_t      bus_i,
  input  wire logic [awc_pkg::DATA_W-1:0] rd_data_o,
  input  wire awc_pkg::awc_conv_t         conv_i,
  input  wire logic                       converter_enable_o,
  input  wire logic                       window_compare_flag_o,
  input  wire logic                       irq_o
);
  logic [WORD_W-1:0] up_m;
  logic [WORD_W-1:0] lo_m;
  logic [WORD_W-1:0] word;
  logic              lj_m;
  logic              mask_m;
  logic              hit;
  logic              taken;
  logic              clr;

  always_comb begin
    word  = lj_m ? {conv_i.result, 4'h0} : {4'h0, conv_i.result};
    hit   = (up_m < lo_m) ? (word > up_m && word < lo_m) : (word < lo_m || word > up_m);
    taken = conv_i.valid && converter_enable_o && hit;
    clr   = bus_i.wr && bus_i.addr == ADDR_CTRL && !bus_i.wdata[CTL_WIN];
  end

  // mirror of the software-visible limit, justify and mask settings
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      up_m   <= UPPER_RST;
      lo_m   <= LOWER_RST;
      lj_m   <= 1'b0;
      mask_m <= 1'b0;
    end else if (bus_i.wr) begin
      case (bus_i.addr)
        ADDR_UPPER_HI: up_m[15:8] <= bus_i.wdata;
        ADDR_UPPER_LO: up_m[7:0] <= bus_i.wdata;
        ADDR_LOWER_HI: lo_m[15:8] <= bus_i.wdata;
        ADDR_LOWER_LO: lo_m[7:0] <= bus_i.wdata;
        ADDR_CTRL:     lj_m <= bus_i.wdata[CTL_LJST];
        ADDR_IRQ_MASK: mask_m <= bus_i.wdata[IRQ_WIN];
        default:       ;
      endcase
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);

  sequence s_hit_taken;
    taken;
  endsequence
  sequence s_ctrl_read;
    bus_i.rd && bus_i.addr == ADDR_CTRL;
  endsequence
  sequence s_upper_hi_read;
    bus_i.rd && bus_i.addr == ADDR_UPPER_HI;
  endsequence

  property p_rd_idle;
    !bus_i.rd |=> rd_data_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero after idle cycle");

  property p_win_set;
    s_hit_taken |=> window_compare_flag_o;
  endproperty
  a_win_set: assert property (p_win_set) else $error("window flag not set by hit");

  property p_win_rise;
    $rose(window_compare_flag_o) |-> $past(taken);
  endproperty
  a_win_rise: assert property (p_win_rise) else $error("window flag rose without hit");

  property p_sticky;
    window_compare_flag_o && !clr |=> window_compare_flag_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("window flag dropped without clear");

  property p_clear;
    window_compare_flag_o && clr && !taken |=> !window_compare_flag_o;
  endproperty
  a_clear: assert property (p_clear) else $error("window flag not cleared by zero write");

  property p_flag_read;
    s_ctrl_read |=> rd_data_o[CTL_WIN] == $past(window_compare_flag_o);
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("control read shows wrong window flag");

  property p_limit_read;
    s_upper_hi_read |=> rd_data_o == up_m[15:8];
  endproperty
  a_limit_read: assert property (p_limit_read) else $error("upper limit high byte read wrong");

  property p_irq;
    s_hit_taken ##0 mask_m |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised by unmasked hit");
endmodule

bind awc_top awc_checker u_chk (.clock_i(clock_i), .srst_i(srst_i), .bus_i(bus_i), .rd_data_o(rd_data_o),
  .conv_i(conv_i), .converter_enable_o(converter_enable_o),
  .window_compare_flag_o(window_compare_flag_o), .irq_o(irq_o));
`default_nettype wire

// [verification/tb_adc_window_compare.sv]
`default_nettype none
module tb_adc_window_compare
  import awc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  awc_bus_req_t bus_i = '0;
  awc_conv_t conv_i;
  logic [7:0] rd_data_o, trk, e8;
  logic conv_busy_i, start, en, burst, flag, irq_o, rd_q, lj = 1'b0, fl = 1'b0;
  logic [1:0] mode;
  logic [11:0] res = '0;
  logic [3:0] dly = '0;
  logic [15:0] up, lo, e, exp_q[$];
  logic [31:0] seed = 32'd39;
  logic [11:0] bnd[8] = '{12'h000, 12'h0FF, 12'h100, 12'h101, 12'h1FF, 12'h200, 12'h201, 12'hFFF};
  int err_total = 0;
  int compares = 0;

  awc_top dut (.clock_i(clock_i), .srst_i(srst_i), .bus_i(bus_i), .rd_data_o(rd_data_o), .conv_i(conv_i),
    .conv_busy_i(conv_busy_i), .conv_start_o(start), .converter_enable_o(en), .burst_mode_enable_o(burst),
    .start_mode_o(mode), .tracking_ctrl_o(trk), .window_compare_flag_o(flag), .irq_o(irq_o));
  awc_conv_model u_conv (.clock_i(clock_i), .srst_i(srst_i), .start_i(start), .result_i(res), .dly_i(dly),
    .conv_o(conv_i), .busy_o(conv_busy_i));

  always #4 clock_i = ~clock_i;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic hit(input logic [15:0] w);
    return (up < lo) ? (w > up && w < lo) : (w < lo || w > up);
  endfunction

  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    compares++;
    if (g !== x) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clock_i);
    bus_i <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clock_i);
    bus_i <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
    exp_q.push_back({m, x & m});
    bus(a, 8'h00, 1'b0);
  endtask

  task automatic setl(input logic [15:0] u, input logic [15:0] l);
    bus(ADDR_UPPER_HI, u[15:8], 1'b1);
    bus(ADDR_UPPER_LO, u[7:0], 1'b1);
    bus(ADDR_LOWER_HI, l[15:8], 1'b1);
    bus(ADDR_LOWER_LO, l[7:0], 1'b1);
    up = u;
    lo = l;
  endtask

  // start one conversion, optionally clearing the window flag in the same write
  task automatic cv(input logic [11:0] r, input logic clr);
    logic [15:0] w;
    w = lj ? {r, 4'h0} : {4'h0, r};
    res = r;
    seed = xs(seed);
    dly = seed[3:0];
    bus(ADDR_CTRL, {4'b1011, !clr, lj, 2'b00}, 1'b1);
    for (int i = 0; i < 40 && conv_i.valid !== 1'b1; i++) @(posedge clock_i);
    fl = (fl && !clr) || hit(w);
    rd(ADDR_CTRL, {3'b101, 1'b0, fl, lj, 2'b00}, 8'hEF);
    rd(ADDR_CONV_HI, w[15:8], 8'hFF);
    rd(ADDR_CONV_LO, w[7:0], 8'hFF);
    chk("window_compare_flag_o", {7'h00, fl}, {7'h00, flag});
  endtask

  // scoreboard: read data appear in the cycle after the read strobe
  always @(posedge clock_i) rd_q <= bus_i.rd;
  always @(negedge clock_i) begin
    if (rd_q) begin
      e = exp_q.pop_front();
      chk("rd_data_o", e[7:0], rd_data_o & e[15:8]);
    end
  end

  task automatic results();
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    results();
  end

  initial begin
    repeat (20) @(posedge clock_i);
    srst_i <= 1'b0;
    rd(ADDR_UPPER_HI, 8'hFF, 8'hFF);
    rd(ADDR_UPPER_LO, 8'hFF, 8'hFF);
    rd(ADDR_LOWER_LO, 8'h00, 8'hFF);
    rd(ADDR_TRACK, 8'hFF, 8'hFF);
    rd(ADDR_CTRL, 8'h00, 8'hFF);
    bus(8'h30, 8'h5A, 1'b1);
    rd(8'h30, 8'h00, 8'hFF);
    setl(16'h0100, 16'h0200);
    rd(ADDR_LOWER_HI, 8'h02, 8'hFF);
    foreach (bnd[i]) cv(bnd[i], 1'b1);
    setl(16'h0200, 16'h0100);
    foreach (bnd[i]) cv(bnd[i], 1'b1);
    lj = 1'b1;
    setl(16'h1000, 16'h2000);
    foreach (bnd[i]) cv(bnd[i], 1'b0);
    for (int k = 0; k < 24; k++) begin
      seed = xs(seed);
      if (k % 6 == 0) begin
        lj = seed[20];
        setl(lj ? {seed[11:0], 4'h0} : {4'h0, seed[11:0]}, lj ? {seed[27:16], 4'h0} : {4'h0, seed[27:16]});
      end
      cv(seed[11:0] ^ seed[31:20], seed[13]);
    end
    rd(ADDR_IRQ_STAT, 8'h02, 8'h02);
    bus(ADDR_IRQ_MASK, 8'h01, 1'b1);
    setl(16'h0000, 16'hFFFF);
    cv(12'h800, 1'b1);
    chk("irq_o", 8'h01, {7'h00, irq_o});
    rd(ADDR_IRQ_STAT, 8'h03, 8'hFF);
    @(negedge clock_i);
    chk("irq_o", 8'h00, {7'h00, irq_o});
    chk("converter_enable_o", 8'h01, {7'h00, en});
    chk("burst_mode_enable_o", 8'h00, {7'h00, burst});
    chk("start_mode_o", 8'h00, {6'h00, mode});
    chk("tracking_ctrl_o", 8'hFF, trk);
    bus(ADDR_TRACK, 8'hA5, 1'b1);
    @(negedge clock_i);
    chk("tracking_ctrl_o", 8'hA5, trk);
    repeat (4) @(posedge clock_i);
    results();
  end
endmodule
`default_nettype wire
